// ---- pdcg_pkg.sv ----
// constants, register map and carrier types for the power-down clock gate block
`default_nettype none
package pdcg_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_SLEEP_CTRL = 5'h00;
  localparam logic [4:0] OFF_FAST_GATES = 5'h04;
  localparam logic [4:0] OFF_PERIPH_GATES = 5'h08;
  localparam logic [4:0] OFF_HEALTH = 5'h0C;
  localparam logic [4:0] OFF_WAKE_SRC_EN = 5'h1C;
  // sleep_and_oscillator_control fields
  localparam int B_FAST_XTAL = 0;
  localparam int B_SLOW_XTAL = 1;
  localparam int B_FAST_INT = 2;
  localparam int B_SLOW_INT = 3;
  localparam int B_WAKE_DLY = 4;
  localparam int B_WAKE_IRQ_EN = 5;
  localparam int B_WAKE_STS = 6;
  localparam int B_PD_EN = 7;
  localparam int B_WAIT_CPU = 8;
  localparam logic [8:0] SLEEP_CTRL_RST = 9'h014;
  // fast_bus_clock_gates
  localparam int B_FLASH_PROG = 2;
  localparam logic [31:0] FAST_GATES_RST = 32'h0000000D;
  localparam logic [31:0] FAST_GATES_FIXED = 32'h00000009;
  // peripheral_bus_clock_gates: writable bits and reset
  localparam logic [31:0] PERIPH_MASK = 32'h8833323F;
  localparam logic [31:0] PERIPH_RST = 32'h00000000;
  localparam int B_WDT_GATE = 0;
  localparam int B_RTC_GATE = 1;
  // clock_health_flags
  localparam int B_SLOW_INT_STB = 3;
  localparam int B_FAST_INT_STB = 4;
  localparam int B_SW_FAIL = 7;
  // wake sources: gpio, usb, uart, watchdog, brown-out, rtc
  localparam int N_WAKE = 6;
  localparam logic [5:0] WAKE_SRC_EN_RST = 6'h3F;
  // default source code of the flash user config meaning fast crystal
  localparam logic [2:0] CFG_SRC_FAST_XTAL = 3'h0;
  localparam int WAKE_DLY_XTAL = 4096;
  localparam int WAKE_DLY_INT = 256;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } pdcg_bus_req_t;

  typedef struct packed {
    logic slow_internal;
    logic fast_internal;
    logic slow_crystal;
    logic fast_crystal;
  } pdcg_osc_t;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_PWRDN  = 2'b01,
    PM_WAKE   = 2'b11,
    PM_IDLE   = 2'b10
  } pdcg_mode_t;
endpackage
`default_nettype wire

// ---- pdcg_wake_delay.sv ----
// wake-up stabilisation counter
`default_nettype none
module pdcg_wake_delay #(
  parameter int LONG_CYC  = 4096,
  parameter int SHORT_CYC = 256
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // control
  input  wire logic start,
  input  wire logic long_delay,
  output logic      done
);
  localparam int CW = $clog2(LONG_CYC + 1);

  // refuse counts that the down-counter cannot serve
  if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_bad_counts
    $error("wake delay counts out of range");
  end

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  always_comb begin
    next_count = count;
    if (start) begin
      next_count = long_delay ? CW'(LONG_CYC) : CW'(SHORT_CYC);
    end else if (count != '0) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // last cycle of the hold-off
  assign done = (count == CW'(1));
endmodule // pdcg_wake_delay
`default_nettype wire

// ---- pdcg_ctrl.sv ----
// power-down control and clock gating with Avalon-MM register slave
`default_nettype none
module pdcg_ctrl #(
  parameter int DLY_XTAL = pdcg_pkg::WAKE_DLY_XTAL,
  parameter int DLY_INT  = pdcg_pkg::WAKE_DLY_INT
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // avalon-mm slave
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [4:0]           avs_address,
  input  wire logic [3:0]           avs_byteenable,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // write protection state from the unlock unit
  input  wire logic                 regs_unlocked,
  // flash user configuration default source
  input  wire logic [2:0]           cfg_default_src,
  // processor side
  input  wire logic                 cpu_sleep,
  output logic                      cpu_clk_en,
  output logic                      wake_irq,
  // wake sources
  input  wire logic [5:0]           wake_src,
  // system clock status
  input  wire logic                 sys_src_is_crystal,
  input  wire logic                 clock_switch_req,
  input  wire logic                 switch_target_stable,
  input  wire logic                 fast_internal_osc_stable,
  input  wire logic                 slow_internal_osc_stable,
  input  wire logic                 wdt_on_slow_clock,
  // clock enables out
  output pdcg_pkg::pdcg_osc_t       osc_enable,
  output logic                      pll_clk_en,
  output logic                      sys_clk_en,
  output logic                      flash_programming_clock_gate,
  output logic [31:0]               periph_clock_gate,
  output logic                      rtc_engine_clk_en,
  output pdcg_pkg::pdcg_mode_t      power_mode
);
  // refuse delays that the wake counter cannot serve
  if (DLY_INT < 1 || DLY_XTAL < DLY_INT) begin : g_bad_dly
    $error("wake delay parameters out of range");
  end

  pdcg_pkg::pdcg_bus_req_t req;
  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 byteenable: avs_byteenable, writedata: avs_writedata};

  // bus slave: one wait cycle, then answer
  logic        ack;
  logic        next_ack;
  logic [31:0] next_readdata;
  logic [31:0] be_mask;
  logic        wr_take;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_be
      assign be_mask[gi*8 +: 8] = {8{req.byteenable[gi]}};
    end
  endgenerate

  assign avs_waitrequest = (req.read || req.write) && !ack;
  assign wr_take = req.write && ack;

  // registers
  logic [8:0]  sleep_ctrl;
  logic [8:0]  next_sleep_ctrl;
  logic        flash_gate;
  logic        next_flash_gate;
  logic [31:0] periph_gates;
  logic [31:0] next_periph_gates;
  logic        sw_fail;
  logic        next_sw_fail;
  logic [5:0]  wake_src_en;
  logic [5:0]  next_wake_src_en;
  logic        cfg_loaded;
  logic        next_cfg_loaded;
  pdcg_pkg::pdcg_mode_t mode;
  pdcg_pkg::pdcg_mode_t next_mode;

  logic        wake_event;
  logic        dly_start;
  logic        dly_done;
  logic        dly_long;
  logic [31:0] wmask;
  logic [31:0] wdata;

  assign wake_event = |(wake_src & wake_src_en);

  pdcg_wake_delay #(
    .LONG_CYC  (DLY_XTAL),
    .SHORT_CYC (DLY_INT)
  ) u_delay (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .start      (dly_start),
    .long_delay (dly_long),
    .done       (dly_done)
  );
  assign dly_long = sys_src_is_crystal;

  // bus read path
  always_comb begin
    next_ack = (req.read || req.write) && !ack;
    next_readdata = avs_readdata;
    if (req.read && !ack) begin
      case (req.address)
        pdcg_pkg::OFF_SLEEP_CTRL:   next_readdata = {23'h0, sleep_ctrl};
        pdcg_pkg::OFF_FAST_GATES:
          next_readdata = pdcg_pkg::FAST_GATES_FIXED |
                          (32'(flash_gate) << pdcg_pkg::B_FLASH_PROG);
        pdcg_pkg::OFF_PERIPH_GATES: next_readdata = periph_gates;
        pdcg_pkg::OFF_HEALTH: begin
          next_readdata = 32'h0;
          next_readdata[pdcg_pkg::B_SW_FAIL] = sw_fail;
          next_readdata[pdcg_pkg::B_FAST_INT_STB] =
            fast_internal_osc_stable && sleep_ctrl[pdcg_pkg::B_FAST_INT];
          next_readdata[pdcg_pkg::B_SLOW_INT_STB] =
            slow_internal_osc_stable && sleep_ctrl[pdcg_pkg::B_SLOW_INT];
        end
        pdcg_pkg::OFF_WAKE_SRC_EN:  next_readdata = {26'h0, wake_src_en};
        default:                    next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
    end
  end

  // register write path and hardware updates
  always_comb begin
    next_sleep_ctrl = sleep_ctrl;
    next_flash_gate = flash_gate;
    next_periph_gates = periph_gates;
    next_sw_fail = sw_fail;
    next_wake_src_en = wake_src_en;
    next_cfg_loaded = 1'b1;
    wmask = be_mask;
    wdata = req.writedata;
    // strap caught once after reset release
    if (!cfg_loaded && cfg_default_src == pdcg_pkg::CFG_SRC_FAST_XTAL) begin
      next_sleep_ctrl[pdcg_pkg::B_FAST_XTAL] = 1'b1;
    end
    if (wr_take) begin
      case (req.address)
        pdcg_pkg::OFF_SLEEP_CTRL: begin
          if (regs_unlocked) begin
            for (int i = 0; i < 9; i++) begin
              if (i != pdcg_pkg::B_WAKE_STS && wmask[i])
                next_sleep_ctrl[i] = wdata[i];
            end
          end
          if (wmask[pdcg_pkg::B_WAKE_STS] && wdata[pdcg_pkg::B_WAKE_STS])
            next_sleep_ctrl[pdcg_pkg::B_WAKE_STS] = 1'b0;
        end
        pdcg_pkg::OFF_FAST_GATES: begin
          if (wmask[pdcg_pkg::B_FLASH_PROG])
            next_flash_gate = wdata[pdcg_pkg::B_FLASH_PROG];
        end
        pdcg_pkg::OFF_PERIPH_GATES: begin
          for (int i = 0; i < 32; i++) begin
            if (wmask[i] && pdcg_pkg::PERIPH_MASK[i] &&
                (i != pdcg_pkg::B_WDT_GATE || regs_unlocked))
              next_periph_gates[i] = wdata[i];
          end
        end
        pdcg_pkg::OFF_HEALTH: begin
          if (regs_unlocked && wmask[pdcg_pkg::B_SW_FAIL] &&
              wdata[pdcg_pkg::B_SW_FAIL])
            next_sw_fail = 1'b0;
        end
        pdcg_pkg::OFF_WAKE_SRC_EN: begin
          for (int i = 0; i < 6; i++) begin
            if (wmask[i])
              next_wake_src_en[i] = wdata[i];
          end
        end
        default: begin
        end
      endcase
    end
    // hardware updates win over software writes
    if (clock_switch_req) begin
      next_sw_fail = !switch_target_stable;
    end
    if (wake_event) begin
      next_sleep_ctrl[pdcg_pkg::B_WAKE_STS] = 1'b1;
    end
    if (mode == pdcg_pkg::PM_PWRDN && wake_event) begin
      next_sleep_ctrl[pdcg_pkg::B_PD_EN] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_ctrl <= pdcg_pkg::SLEEP_CTRL_RST;
      flash_gate <= pdcg_pkg::FAST_GATES_RST[pdcg_pkg::B_FLASH_PROG];
      periph_gates <= pdcg_pkg::PERIPH_RST;
      sw_fail <= 1'b0;
      wake_src_en <= pdcg_pkg::WAKE_SRC_EN_RST;
      cfg_loaded <= 1'b0;
    end else begin
      sleep_ctrl <= next_sleep_ctrl;
      flash_gate <= next_flash_gate;
      periph_gates <= next_periph_gates;
      sw_fail <= next_sw_fail;
      wake_src_en <= next_wake_src_en;
      cfg_loaded <= next_cfg_loaded;
    end
  end

  // power mode sequencer
  logic pd_en;
  logic wait_cpu;
  assign pd_en = sleep_ctrl[pdcg_pkg::B_PD_EN];
  assign wait_cpu = sleep_ctrl[pdcg_pkg::B_WAIT_CPU];

  always_comb begin
    next_mode = mode;
    dly_start = 1'b0;
    case (mode)
      pdcg_pkg::PM_ACTIVE: begin
        if (pd_en && !wait_cpu) begin
          next_mode = pdcg_pkg::PM_PWRDN;
        end else if (pd_en && wait_cpu && cpu_sleep) begin
          next_mode = pdcg_pkg::PM_PWRDN;
        end else if (!pd_en && !wait_cpu && cpu_sleep) begin
          next_mode = pdcg_pkg::PM_IDLE;
        end
      end
      pdcg_pkg::PM_IDLE: begin
        if (!cpu_sleep) begin
          next_mode = pdcg_pkg::PM_ACTIVE;
        end else if (pd_en && (!wait_cpu || cpu_sleep)) begin
          next_mode = pdcg_pkg::PM_PWRDN;
        end
      end
      pdcg_pkg::PM_PWRDN: begin
        if (wake_event) begin
          if (sleep_ctrl[pdcg_pkg::B_WAKE_DLY]) begin
            next_mode = pdcg_pkg::PM_WAKE;
            dly_start = 1'b1;
          end else begin
            next_mode = pdcg_pkg::PM_ACTIVE;
          end
        end
      end
      pdcg_pkg::PM_WAKE: begin
        if (dly_done) begin
          next_mode = pdcg_pkg::PM_ACTIVE;
        end
      end
      default: next_mode = pdcg_pkg::PM_ACTIVE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode <= pdcg_pkg::PM_ACTIVE;
    end else begin
      mode <= next_mode;
    end
  end

  // clock enables
  logic clocks_held;
  // the hold-off keeps crystals running so they can settle
  assign clocks_held = (mode == pdcg_pkg::PM_PWRDN) ||
                       (mode == pdcg_pkg::PM_WAKE);
  assign power_mode = mode;
  assign wake_irq = sleep_ctrl[pdcg_pkg::B_WAKE_STS] &&
                    sleep_ctrl[pdcg_pkg::B_WAKE_IRQ_EN];

  always_comb begin
    osc_enable.fast_crystal = sleep_ctrl[pdcg_pkg::B_FAST_XTAL] &&
                              mode != pdcg_pkg::PM_PWRDN;
    osc_enable.fast_internal = sleep_ctrl[pdcg_pkg::B_FAST_INT] &&
                               mode != pdcg_pkg::PM_PWRDN;
    osc_enable.slow_crystal = sleep_ctrl[pdcg_pkg::B_SLOW_XTAL];
    osc_enable.slow_internal = sleep_ctrl[pdcg_pkg::B_SLOW_INT];
  end

  assign sys_clk_en = !clocks_held;
  assign pll_clk_en = !clocks_held;
  assign cpu_clk_en = !clocks_held && mode != pdcg_pkg::PM_IDLE;
  assign flash_programming_clock_gate = flash_gate && !clocks_held;
  assign rtc_engine_clk_en = 1'b1;

  always_comb begin
    periph_clock_gate = periph_gates & {32{!clocks_held}};
    // watchdog on the slow oscillator survives power-down
    periph_clock_gate[pdcg_pkg::B_WDT_GATE] =
      periph_gates[pdcg_pkg::B_WDT_GATE] &&
      (!clocks_held || wdt_on_slow_clock);
  end
endmodule // pdcg_ctrl
`default_nettype wire

// ---- pdcg_ctrl_sva.sv ----
// checker on the ports of the power-down clock gate block
`default_nettype none
module pdcg_ctrl_sva #(
  parameter int DLY_XTAL = pdcg_pkg::WAKE_DLY_XTAL,
  parameter int DLY_INT  = pdcg_pkg::WAKE_DLY_INT
) (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  // register bus
  input wire logic                 avs_write,
  input wire logic                 avs_waitrequest,
  input wire logic [4:0]           avs_address,
  input wire logic [3:0]           avs_byteenable,
  input wire logic [31:0]          avs_writedata,
  input wire logic                 regs_unlocked,
  // wake and clock outputs
  input wire logic [5:0]           wake_src,
  input wire logic                 sys_src_is_crystal,
  input wire logic                 cpu_clk_en,
  input wire pdcg_pkg::pdcg_osc_t  osc_enable,
  input wire logic                 pll_clk_en,
  input wire logic                 sys_clk_en,
  input wire logic                 flash_programming_clock_gate,
  input wire logic [31:0]          periph_clock_gate,
  input wire logic                 rtc_engine_clk_en,
  input wire pdcg_pkg::pdcg_mode_t power_mode
);
  logic [15:0] wcnt;
  logic [15:0] next_wcnt;
  logic [15:0] dly;
  logic        pd_arm;
  assign dly = sys_src_is_crystal ? 16'(DLY_XTAL) : 16'(DLY_INT);
  assign pd_arm = avs_write && !avs_waitrequest && regs_unlocked &&
                  avs_address == pdcg_pkg::OFF_SLEEP_CTRL &&
                  avs_byteenable == 4'hF && avs_writedata[8:7] == 2'b01;
  always_comb begin
    next_wcnt = 16'h0000;
    if (power_mode == pdcg_pkg::PM_WAKE) next_wcnt = wcnt + 16'h0001;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) wcnt <= 16'h0000;
    else wcnt <= next_wcnt;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_pd_enter_now: assert property (
    pd_arm && power_mode == pdcg_pkg::PM_ACTIVE ##1 wake_src == 6'h00
    |=> power_mode == pdcg_pkg::PM_PWRDN)
    else $error("power-down not entered at once");
  a_pd_osc_off: assert property (
    power_mode == pdcg_pkg::PM_PWRDN |-> !osc_enable.fast_crystal &&
    !osc_enable.fast_internal && !pll_clk_en && !sys_clk_en && !cpu_clk_en)
    else $error("fast clocks running in power-down");
  a_pd_slow_keep: assert property (
    power_mode == pdcg_pkg::PM_PWRDN |->
    $stable({osc_enable.slow_internal, osc_enable.slow_crystal}))
    else $error("slow source enables moved in power-down");
  a_wake_len: assert property (
    $fell(power_mode == pdcg_pkg::PM_WAKE) |->
    wcnt == dly || wcnt == dly + 16'h0001)
    else $error("wake delay length wrong");
  a_pd_no_reenter: assert property (
    $fell(power_mode == pdcg_pkg::PM_PWRDN) |->
    (power_mode != pdcg_pkg::PM_PWRDN) [*2])
    else $error("power-down enable not cleared on wake");
  a_wake_exit: assert property (
    power_mode == pdcg_pkg::PM_PWRDN && wake_src != 6'h00 |=>
    power_mode inside {pdcg_pkg::PM_WAKE, pdcg_pkg::PM_ACTIVE})
    else $error("wake event did not leave power-down");
  a_gates_follow: assert property (
    !sys_clk_en |-> !flash_programming_clock_gate &&
    periph_clock_gate[31:1] == 31'h0)
    else $error("bus clock gate open while system clock off");
  a_rtc_engine_on: assert property (rtc_engine_clk_en)
    else $error("rtc engine clock stopped");
  a_idle_cpu_only: assert property (
    power_mode == pdcg_pkg::PM_IDLE |-> !cpu_clk_en && sys_clk_en &&
    pll_clk_en)
    else $error("idle mode stops more than the cpu clock");
  c_pwrdn: cover property (power_mode == pdcg_pkg::PM_PWRDN);
  c_wake: cover property (power_mode == pdcg_pkg::PM_WAKE);
  c_idle: cover property (power_mode == pdcg_pkg::PM_IDLE);
endmodule // pdcg_ctrl_sva

bind pdcg_ctrl pdcg_ctrl_sva #(.DLY_XTAL(DLY_XTAL), .DLY_INT(DLY_INT))
  i_pdcg_ctrl_sva (.sys_clk(sys_clk), .resetn(resetn),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_address(avs_address), .avs_byteenable(avs_byteenable),
  .avs_writedata(avs_writedata), .regs_unlocked(regs_unlocked),
  .wake_src(wake_src), .sys_src_is_crystal(sys_src_is_crystal),
  .cpu_clk_en(cpu_clk_en), .osc_enable(osc_enable),
  .pll_clk_en(pll_clk_en), .sys_clk_en(sys_clk_en),
  .flash_programming_clock_gate(flash_programming_clock_gate),
  .periph_clock_gate(periph_clock_gate),
  .rtc_engine_clk_en(rtc_engine_clk_en), .power_mode(power_mode));
`default_nettype wire

// ---- pdcg_cpu_model.sv ----
// processor core stand-in: sleeps on command, wakes on interrupt
`default_nettype none
module pdcg_cpu_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // bench commands
  input  wire logic run_wfi,
  input  wire logic irq_pending,
  // to the block
  output logic      cpu_sleep
);
  timeunit 1ns;
  timeprecision 1ps;
  logic next_sleep;
  // sleep holds until an interrupt, as a real core stays in wfi
  always_comb begin
    next_sleep = cpu_sleep;
    if (irq_pending) next_sleep = 1'b0;
    else if (run_wfi) next_sleep = 1'b1;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) cpu_sleep <= 1'b0;
    else cpu_sleep <= next_sleep;
  end
endmodule // pdcg_cpu_model
`default_nettype wire

// ---- tb_pdcg_ctrl.sv ----
// self-checking bench for the power-down clock gate block
`default_nettype none
module tb_pdcg_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DX = 16;
  localparam int DI = 4;
  logic                 sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic                 regs_unlocked, cpu_sleep, cpu_clk_en, wake_irq;
  logic                 sys_src_is_crystal, clock_switch_req, switch_stb;
  logic                 fast_stb, slow_stb, wdt_slow, pll_clk_en, sys_clk_en;
  logic                 flash_gate, rtc_on, run_wfi, irq_pending;
  logic [2:0]           cfg_default_src;
  logic [3:0]           avs_byteenable;
  logic [4:0]           avs_address;
  logic [5:0]           wake_src;
  logic [31:0]          avs_writedata, avs_readdata, periph_gate, rd;
  pdcg_pkg::pdcg_osc_t  osc_enable;
  pdcg_pkg::pdcg_mode_t power_mode;
  int                   errors = 0;
  int                   num_checks = 0;
  int                   cyc = 0;

  pdcg_ctrl #(.DLY_XTAL(DX), .DLY_INT(DI)) i_pdcg_ctrl (
    .sys_clk(sys_clk), .resetn(resetn), .avs_read(avs_read),
    .avs_write(avs_write), .avs_address(avs_address),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .regs_unlocked(regs_unlocked), .cfg_default_src(cfg_default_src),
    .cpu_sleep(cpu_sleep), .cpu_clk_en(cpu_clk_en), .wake_irq(wake_irq),
    .wake_src(wake_src), .sys_src_is_crystal(sys_src_is_crystal),
    .clock_switch_req(clock_switch_req), .switch_target_stable(switch_stb),
    .fast_internal_osc_stable(fast_stb), .slow_internal_osc_stable(slow_stb),
    .wdt_on_slow_clock(wdt_slow), .osc_enable(osc_enable),
    .pll_clk_en(pll_clk_en), .sys_clk_en(sys_clk_en),
    .flash_programming_clock_gate(flash_gate),
    .periph_clock_gate(periph_gate), .rtc_engine_clk_en(rtc_on),
    .power_mode(power_mode));
  pdcg_cpu_model i_pdcg_cpu_model (.sys_clk(sys_clk), .resetn(resetn),
    .run_wfi(run_wfi), .irq_pending(irq_pending), .cpu_sleep(cpu_sleep));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end

  task automatic close_out;
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // request stands until waitrequest is sampled low at a rising edge
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask
  task automatic wait_mode(input pdcg_pkg::pdcg_mode_t m);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (power_mode !== m && n < 64);
    chk({30'h0, power_mode}, {30'h0, m});
    @(posedge sys_clk);
  endtask
  task automatic pulse(input logic sw, input logic wfi, input logic irq);
    clock_switch_req <= sw;
    run_wfi <= wfi;
    irq_pending <= irq;
    @(posedge sys_clk);
    {clock_switch_req, run_wfi, irq_pending} <= 3'h0;
    @(posedge sys_clk);
  endtask

  task automatic t_reset;
    rdchk(5'h00, 32'h00000015);
    rdchk(5'h04, 32'h0000000D);
    rdchk(5'h08, 32'h00000000);
    rdchk(5'h0C, 32'h00000010);
    chk({28'h0, osc_enable}, 32'h00000005);
    chk({31'h0, rtc_on}, 32'h00000001);
    rdchk(5'h1C, 32'h0000003F);
    wr(5'h10, 32'hFFFFFFFF);
    rdchk(5'h10, 32'h00000000);
  endtask
  task automatic t_protect;
    regs_unlocked <= 1'b0;
    wr(5'h00, 32'h0000000F);
    rdchk(5'h00, 32'h00000015);
    wr(5'h08, 32'hFFFFFFFF);
    rdchk(5'h08, 32'h8833323E);
    regs_unlocked <= 1'b1;
    wr(5'h08, 32'hFFFFFFFF);
    rdchk(5'h08, 32'h8833323F);
    chk(periph_gate, 32'h8833323F);
    wr(5'h04, 32'h00000000);
    rdchk(5'h04, 32'h00000009);
    chk({31'h0, flash_gate}, 32'h00000000);
    wr(5'h04, 32'h00000004);
    chk({31'h0, flash_gate}, 32'h00000001);
  endtask
  task automatic t_switch;
    switch_stb <= 1'b0;
    pulse(1'b1, 1'b0, 1'b0);
    rdchk(5'h0C, 32'h00000090);
    wr(5'h0C, 32'h00000080);
    rdchk(5'h0C, 32'h00000010);
    pulse(1'b1, 1'b0, 1'b0);
    switch_stb <= 1'b1;
    pulse(1'b1, 1'b0, 1'b0);
    rdchk(5'h0C, 32'h00000010);
  endtask
  task automatic t_idle;
    wr(5'h00, 32'h0000000F);
    pulse(1'b0, 1'b1, 1'b0);
    wait_mode(pdcg_pkg::PM_IDLE);
    chk({30'h0, cpu_clk_en, sys_clk_en}, 32'h00000001);
    pulse(1'b0, 1'b0, 1'b1);
    wait_mode(pdcg_pkg::PM_ACTIVE);
  endtask
  task automatic t_pd_now;
    // wake sources are left enabled from reset before arming
    wr(5'h00, 32'h000000AF);
    wait_mode(pdcg_pkg::PM_PWRDN);
    chk({28'h0, osc_enable}, 32'h0000000A);
    chk(periph_gate, 32'h00000001);
    chk({30'h0, pll_clk_en, sys_clk_en}, 32'h00000000);
    wdt_slow <= 1'b0;
    @(posedge sys_clk);
    chk(periph_gate, 32'h00000000);
    wdt_slow <= 1'b1;
    wake_src <= 6'h04;
    wait_mode(pdcg_pkg::PM_ACTIVE);
    wake_src <= 6'h00;
    chk({31'h0, wake_irq}, 32'h00000001);
    rdchk(5'h00, 32'h0000006F);
    wr(5'h00, 32'h0000006F);
    rdchk(5'h00, 32'h0000002F);
    chk({31'h0, wake_irq}, 32'h00000000);
  endtask
  task automatic t_pd_wait;
    int n;
    for (int s = 1; s >= 0; s--) begin
      sys_src_is_crystal <= s[0];
      wr(5'h00, 32'h0000019F);
      repeat (8) @(posedge sys_clk);
      chk({30'h0, power_mode}, 32'h00000000);
      pulse(1'b0, 1'b1, 1'b0);
      wait_mode(pdcg_pkg::PM_PWRDN);
      wake_src <= 6'h20;
      n = 0;
      repeat (64) begin
        @(negedge sys_clk);
        if (power_mode === pdcg_pkg::PM_WAKE) n++;
      end
      chk(n, (s == 1) ? DX : DI);
      @(posedge sys_clk);
      wake_src <= 6'h00;
      pulse(1'b0, 1'b0, 1'b1);
      rdchk(5'h00, 32'h0000015F);
      chk({31'h0, wake_irq}, 32'h00000000);
    end
  endtask
  // second reset with the internal oscillator as default source
  task automatic t_cfg;
    resetn <= 1'b0;
    cfg_default_src <= 3'h7;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rdchk(5'h00, 32'h00000014);
    chk({28'h0, osc_enable}, 32'h00000004);
  endtask

  initial begin
    {resetn, avs_read, avs_write, clock_switch_req, run_wfi} = 5'h00;
    {irq_pending, switch_stb, regs_unlocked} = 3'h0;
    {fast_stb, slow_stb, wdt_slow, sys_src_is_crystal} = 4'hF;
    avs_address = 5'h00;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h00000000;
    cfg_default_src = 3'h0;
    wake_src = 6'h00;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_protect();
    t_switch();
    t_idle();
    t_pd_now();
    t_pd_wait();
    t_cfg();
    close_out();
  end
endmodule // tb_pdcg_ctrl
`default_nettype wire
